// ### design/rcs_select.sv
/*
 control and squelch logic of the second recovered clock output.
 assumes port status comes from other clock domains and a clock gate
 and mux downstream that follow the registered select and enable.
*/
// How it works
// - control bit 15 enables the output; cleared at reset.
// - bits 14:11 pick source port 0..3; other codes reserved; reset 0.
// - bits 10:8 pick 25, 125 or 31.25 MHz; others reserved.
// - squelch code 00: low when link down or unstable.
// - code 00: also low in gigabit master or 10 Mb/s link.
// - code 00: also low in energy-efficient 100M or gigabit slave.
// - code 01: as 00 but gigabit master and 10 Mb/s give clock.
// - code 01: energy-efficient mode keeps clock while idle received.
// - code 10: low only when link is down.
// - code 11: no automatic squelch at all.
// - code 11 with link down still drives the selected clock.
// - external squelch pin high silences output, overriding registers.
// - bits 2:0 pick serial-media or copper clock; others reserved.
`timescale 1ns/1ps

module rcs_select
(
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rd_data_o,
	input  wire logic        squelch_pin_i,
	input  wire logic [3:0]  link_up_i,
	input  wire logic [3:0]  link_stable_i,
	input  wire logic [7:0]  link_speed_i,
	input  wire logic [3:0]  gig_master_i,
	input  wire logic [3:0]  eee_on_i,
	input  wire logic [3:0]  lpi_rx_i,
	output logic             second_recovered_clock_out_en_o,
	output logic      [1:0]  clk_port_o,
	output logic             clk_type_o,
	output logic      [1:0]  clk_freq_o
);

	// ************************************
	// types and storage
	// ************************************
	typedef enum logic [2:0]
	{
		ST_OFF  = 3'b001,
		ST_HOLD = 3'b010,
		ST_ON   = 3'b100
	} rcs_state_e;

	rcs_state_e  state;
	rcs_state_e  next_state;
	logic [15:0] ctrl;
	logic [3:0]  quiet_cnt;
	logic [4:0]  sync_a_pin;
	logic [4:0]  sync_b_pin;
	logic [27:0] sync_a_st;
	logic [27:0] sync_b_st;

	// ************************************
	// input synchronisers
	// ************************************
	// status comes from port logic on other clocks and the pin from
	// the board, so everything passes two flops before use
	// a speed change may show a mixed code for one cycle; the quiet
	// time keeps such a glitch from ever starting the clock
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			sync_a_pin <= 5'h00;
			sync_b_pin <= 5'h00;
		end
		else
		begin
			sync_a_pin <= {squelch_pin_i, link_up_i};
			sync_b_pin <= sync_a_pin;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			sync_a_st <= 28'h0000000;
			sync_b_st <= 28'h0000000;
		end
		else
		begin
			sync_a_st <= {link_stable_i, link_speed_i, gig_master_i,
				eee_on_i, lpi_rx_i, 4'h0};
			sync_b_st <= sync_a_st;
		end
	end

	// ************************************
	// synchronised views
	// ************************************
	logic       pin_sq;
	logic [3:0] up_s;
	logic [3:0] stable_s;
	logic [7:0] speed_s;
	logic [3:0] master_s;
	logic [3:0] eee_s;
	logic [3:0] lpi_s;

	assign pin_sq   = sync_b_pin[4];
	assign up_s     = sync_b_pin[3:0];
	assign stable_s = sync_b_st[27:24];
	assign speed_s  = sync_b_st[23:16];
	assign master_s = sync_b_st[15:12];
	assign eee_s    = sync_b_st[11:8];
	assign lpi_s    = sync_b_st[7:4];

	// ************************************
	// control fields
	// ************************************
	logic       f_en;
	logic [3:0] f_src;
	logic [2:0] f_frq;
	logic [1:0] f_sql;
	logic [2:0] f_typ;

	assign f_en  = ctrl[rcs_pkg::EN_BIT];
	assign f_src = ctrl[rcs_pkg::SRC_HI:rcs_pkg::SRC_LO];
	assign f_frq = ctrl[rcs_pkg::FRQ_HI:rcs_pkg::FRQ_LO];
	assign f_sql = ctrl[rcs_pkg::SQL_HI:rcs_pkg::SQL_LO];
	assign f_typ = ctrl[rcs_pkg::TYP_HI:rcs_pkg::TYP_LO];

	// ************************************
	// squelch decision
	// ************************************
	function automatic logic auto_sq
	(
		input logic [1:0] level,
		input logic       up,
		input logic       stable,
		input logic [1:0] speed,
		input logic       master,
		input logic       eee,
		input logic       lpi
	);
		logic no_rclk;
		logic eee_mode;
		logic res;
		no_rclk  = up && ((speed == rcs_pkg::SPD_10) ||
			((speed == rcs_pkg::SPD_1000) && master));
		eee_mode = up && eee && ((speed == rcs_pkg::SPD_100) ||
			((speed == rcs_pkg::SPD_1000) && !master));
		case (level)
			rcs_pkg::SQL_FULL: res = !up || !stable || no_rclk || eee_mode;
			rcs_pkg::SQL_SOFT: res = !up || !stable || (eee_mode && !lpi);
			rcs_pkg::SQL_LINK: res = !up;
			default:           res = 1'b0;
		endcase
		return res;
	endfunction : auto_sq

	logic [1:0] port;
	logic       sel_ok;
	logic       want_off;
	logic       sel_diff;

	// only the low source bits are applied, which is enough because
	// reserved codes never reach the applied selection
	assign port = f_src[1:0];

	assign sel_ok = (f_src <= rcs_pkg::SRC_MAX) &&
		(f_frq <= rcs_pkg::FRQ_MAX) && (f_typ <= rcs_pkg::TYP_MAX);

	logic auto_now;

	assign auto_now = auto_sq(f_sql, up_s[port], stable_s[port],
		speed_s[2*port +: 2], master_s[port], eee_s[port], lpi_s[port]);

	assign want_off = pin_sq || !f_en || !sel_ok || auto_now;

	// a change of source while running is handled as a stop and
	// restart, so the mux never switches under a live clock except at reset, which clears select and enable at the same edge
	assign sel_diff = (clk_port_o != port) ||
		(clk_type_o != f_typ[0]) || (clk_freq_o != f_frq[1:0]);

	// ************************************
	// output sequencer
	// ************************************
	always_comb
	begin
		next_state = state;
		case (state)
			ST_OFF:
			begin
				if (!want_off)
				begin
					next_state = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				if (want_off || sel_diff)
				begin
					next_state = ST_OFF;
				end
				else if (quiet_cnt == rcs_pkg::QUIET_LAST)
				begin
					next_state = ST_ON;
				end
			end
			ST_ON:
			begin
				if (want_off || sel_diff)
				begin
					next_state = ST_OFF;
				end
			end
			default:
			begin
				next_state = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			state <= ST_OFF;
		end
		else
		begin
			state <= next_state;
		end
	end

	// four bits hold the quiet count at this clock rate
	// quiet time before restart
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i || state != ST_HOLD)
		begin
			quiet_cnt <= 4'h0;
		end
		else
		begin
			quiet_cnt <= quiet_cnt + 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			second_recovered_clock_out_en_o <= 1'b0;
		end
		else
		begin
			second_recovered_clock_out_en_o <= (next_state == ST_ON);
		end
	end

	// selection is only taken over while the output is held low
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			clk_port_o <= 2'h0;
			clk_type_o <= 1'b0;
			clk_freq_o <= 2'h0;
		end
		else if (state == ST_OFF && sel_ok)
		begin
			clk_port_o <= port;
			clk_type_o <= f_typ[0];
			clk_freq_o <= f_frq[1:0];
		end
	end

	// ************************************
	// register port
	// ************************************
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			ctrl <= rcs_pkg::CTRL_RST;
		end
		else if (wr_i && addr_i == rcs_pkg::CTRL_OFS)
		begin
			ctrl <= wr_data_i & rcs_pkg::CTRL_WMASK;
		end
	end

	// status word lets software see why the output is held low;
	// it is read only, so writes to its address are dropped
	logic [15:0] stat;

	assign stat = {8'h00, 1'b0, state, sel_ok, auto_now, pin_sq,
		second_recovered_clock_out_en_o};

	// unmapped addresses read as zero
	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			rd_data_o <= 16'h0000;
		end
		else if (rd_i && addr_i == rcs_pkg::CTRL_OFS)
		begin
			rd_data_o <= ctrl;
		end
		else if (rd_i && addr_i == rcs_pkg::STAT_OFS)
		begin
			rd_data_o <= stat;
		end
		else
		begin
			rd_data_o <= 16'h0000;
		end
	end

endmodule : rcs_select

// ### design/rcs_pkg.sv
/*
 recovered clock 2 select: constants of the design; the bench uses its own literals.
 assumes a 20 MHz system clock and a 16-bit register port.
*/
package rcs_pkg;

	// ************************************
	// register map
	// ************************************
	localparam logic [7:0]  CTRL_OFS   = 8'h18;
	localparam logic [7:0]  STAT_OFS   = 8'h19;
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'hff37;

	// ************************************
	// control field positions
	// ************************************
	localparam int EN_BIT  = 15;
	localparam int SRC_HI  = 14;
	localparam int SRC_LO  = 11;
	localparam int FRQ_HI  = 10;
	localparam int FRQ_LO  = 8;
	localparam int SQL_HI  = 5;
	localparam int SQL_LO  = 4;
	localparam int TYP_HI  = 2;
	localparam int TYP_LO  = 0;

	// ************************************
	// field codes
	// ************************************
	localparam logic [3:0] SRC_MAX   = 4'h3;
	localparam logic [2:0] FRQ_MAX   = 3'h2;
	localparam logic [2:0] TYP_MAX   = 3'h1;
	localparam logic [1:0] SQL_FULL  = 2'h0;
	localparam logic [1:0] SQL_SOFT  = 2'h1;
	localparam logic [1:0] SQL_LINK  = 2'h2;
	localparam logic [1:0] SQL_NONE  = 2'h3;
	localparam logic [1:0] SPD_10    = 2'h0;
	localparam logic [1:0] SPD_100   = 2'h1;
	localparam logic [1:0] SPD_1000  = 2'h2;

	// ************************************
	// timing
	// ************************************
	localparam int CLK_MHZ     = 20;
	localparam int QUIET_NS    = 200;
	localparam int QUIET_CYC   = (QUIET_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] QUIET_LAST = 4'(QUIET_CYC - 1);

endpackage : rcs_pkg

// ### test/rcs_select_checker.sv
/*
 port checker of the recovered clock select.
 assumes it is bound onto rcs_select.
*/
`timescale 1ns/1ps
module rcs_select_checker
(
	input  wire logic        sys_clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] rd_data_o,
	input  wire logic        squelch_pin_i,
	input  wire logic        second_recovered_clock_out_en_o,
	input  wire logic [1:0]  clk_port_o,
	input  wire logic        clk_type_o,
	input  wire logic [1:0]  clk_freq_o
);
	// ****************
	// properties
	// ****************
	wire en = second_recovered_clock_out_en_o;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	property p_pin; squelch_pin_i [*4] |-> !en; endproperty
	property p_quiet; $fell(en) |-> !en [*4]; endproperty
	property p_rise; $rose(en) |-> !$past(en, 2) && !$past(en, 5); endproperty
	property p_sel; en && $past(en) |-> $stable(clk_port_o) && $stable(clk_type_o) && $stable(clk_freq_o); endproperty
	property p_freq; clk_freq_o != 2'h3; endproperty
	property p_idle; !rd_i |=> rd_data_o == 16'h0000; endproperty
	property p_rsv; rd_i && addr_i == 8'h18 |=> rd_data_o[7:6] == 2'h0 && !rd_data_o[3]; endproperty
	property p_wrrd;
		wr_i && addr_i == 8'h18 ##1 !wr_i ##1 rd_i && addr_i == 8'h18 |=> rd_data_o == ($past(wr_data_i, 3) & 16'hff37);
	endproperty
	property p_off;
		wr_i && addr_i == 8'h18 && (!wr_data_i[15] || wr_data_i[14:11] > 4'h3 || wr_data_i[10:8] > 3'h2
			|| wr_data_i[2:0] > 3'h1) |-> ##3 !en;
	endproperty
	a_pin: assert property (p_pin) else $error("output on under squelch pin");
	a_quiet: assert property (p_quiet) else $error("output restarted too soon");
	a_rise: assert property (p_rise) else $error("output started without quiet time");
	a_sel: assert property (p_sel) else $error("selection changed while running");
	a_freq: assert property (p_freq) else $error("reserved frequency applied");
	a_idle: assert property (p_idle) else $error("read data outside read slot");
	a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
	a_wrrd: assert property (p_wrrd) else $error("control readback wrong");
	a_off: assert property (p_off) else $error("output on with disable or reserved code");
	c_on: cover property ($rose(en));
	c_pin: cover property (squelch_pin_i && en);
	c_wrrd: cover property (wr_i ##2 rd_i);
endmodule : rcs_select_checker

bind rcs_select rcs_select_checker rcs_select_checker_inst (.sys_clk_i, .srst_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
	.rd_data_o, .squelch_pin_i, .second_recovered_clock_out_en_o, .clk_port_o, .clk_type_o, .clk_freq_o);

// ### test/rcs_sync_partner.sv
/*
 board timing circuit that consumes the clock and owns the squelch pin.
 assumes one system clock.
*/
`timescale 1ns/1ps
module rcs_sync_partner
(
	input  wire logic sys_clk_i,
	input  wire logic squelch_req_i,
	output logic      squelch_pin_o
);
	// ****************
	// squelch pin
	// ****************
	initial squelch_pin_o = 1'b0;
	always @(posedge sys_clk_i)
	begin
		squelch_pin_o <= squelch_req_i;
	end
endmodule : rcs_sync_partner

// ### test/rcs_select_test.sv
/*
 testbench of the recovered clock select.
 assumes the rcs_select ports and a 20 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module rcs_select_test;
	// ****************
	// stimulus
	// ****************
	logic        sys_clk_i = 1'b0;
	logic        srst_i    = 1'b1;
	logic [7:0]  addr_i    = 8'h00;
	logic [15:0] wr_data_i = 16'h0000;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic        req       = 1'b0;
	logic [3:0]  up        = 4'h0;
	logic [3:0]  st        = 4'h0;
	logic [3:0]  ms        = 4'h0;
	logic [3:0]  ee        = 4'h0;
	logic [3:0]  lp        = 4'h0;
	logic [7:0]  spd       = 8'h00;
	logic [15:0] rd_data_o;
	logic        pin;
	logic        en_o;
	logic [1:0]  port_o;
	logic [1:0]  freq_o;
	logic        type_o;
	logic [15:0] v;
	// up, stable, speed, master, eee, idle, enable per squelch code
	logic [10:0] cs [8] = '{11'h088, 11'h48c, 11'h68f, 11'h74e, 11'h60e, 11'h6ac, 11'h6be, 11'h73e};
	logic [15:0] rs [3] = '{16'ha030, 16'h8330, 16'h8032};
	int          bad_count    = 0;
	int          total_checks = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	rcs_select rcs_select_inst (.sys_clk_i, .srst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
		.squelch_pin_i(pin), .link_up_i(up), .link_stable_i(st), .link_speed_i(spd), .gig_master_i(ms),
		.eee_on_i(ee), .lpi_rx_i(lp), .second_recovered_clock_out_en_o(en_o), .clk_port_o(port_o),
		.clk_type_o(type_o), .clk_freq_o(freq_o));
	rcs_sync_partner rcs_sync_partner_inst (.sys_clk_i, .squelch_req_i(req), .squelch_pin_o(pin));
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		addr_i    <= a;
		wr_data_i <= d;
		wr_i      <= 1'b1;
		@(posedge sys_clk_i);
		wr_i      <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		rd_i   <= 1'b0;
		#1 d = rd_data_o;
	endtask : rd
	task settle;
		repeat (10) @(posedge sys_clk_i);
		#1;
	endtask : settle
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (4000) @(posedge sys_clk_i);
		bad_count++;
		stop_test();
	end
	initial
	begin
		int          c;
		logic [10:0] k;
		logic [1:0]  p;
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		rd(8'h18, v);
		`CHK("ctrl reset", 16'h0000, v)
		`CHK("enable reset", 1'b0, en_o)
		wr(8'h18, 16'h7fff);
		rd(8'h18, v);
		`CHK("ctrl mask", 16'h7f37, v)
		for (int i = 0; i < 32; i++)
		begin
			k = cs[i / 4];
			c = i % 4;
			p = 2'(i / 4);
			wr(8'h18, 16'h0000);
			up  <= k[10] ? (4'h1 << p) : ~(4'h1 << p);
			st  <= {4{k[9]}};
			spd <= {4{k[8:7]}};
			ms  <= {4{k[6]}};
			ee  <= {4{k[5]}};
			lp  <= {4{k[4]}};
			wr(8'h18, {3'h4, p, 3'(i % 3), 2'h0, 2'(c), 3'h0, c[0]});
			settle();
			`CHK("enable", k[c], en_o)
			if (k[c])
			begin
				`CHK("port", p, port_o)
				`CHK("freq", 2'(i % 3), freq_o)
				`CHK("type", c[0], type_o)
			end
		end
		wr(8'h18, 16'h8030);
		settle();
		@(posedge sys_clk_i);
		req <= 1'b1;
		settle();
		`CHK("pin squelch", 1'b0, en_o)
		rd(8'h19, v);
		`CHK("status squelched", 16'h001a, v)
		@(posedge sys_clk_i);
		req <= 1'b0;
		settle();
		`CHK("restart", 1'b1, en_o)
		rd(8'h19, v);
		`CHK("status running", 16'h0049, v)
		wr(8'h19, 16'hffff);
		rd(8'h18, v);
		`CHK("status write ignored", 16'h8030, v)
		foreach (rs[j])
		begin
			wr(8'h18, 16'h8030);
			settle();
			wr(8'h18, rs[j]);
			settle();
			`CHK("reserved code", 1'b0, en_o)
		end
		rd(8'h20, v);
		`CHK("unmapped", 16'h0000, v)
		wr(8'h18, 16'h9930);
		settle();
		`CHK("enable before reset", 1'b1, en_o)
		`CHK("port before reset", 2'h3, port_o)
		`CHK("freq before reset", 2'h1, freq_o)
		@(posedge sys_clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		rd(8'h18, v);
		`CHK("ctrl mid reset", 16'h0000, v)
		`CHK("enable mid reset", 1'b0, en_o)
		`CHK("port mid reset", 2'h0, port_o)
		`CHK("freq mid reset", 2'h0, freq_o)
		stop_test();
	end
endmodule : rcs_select_test
